// [verilog/uart_pkg.sv]
// Overview of operation
// - Sleep bit set puts receiver asleep
// - Asleep: no flag updates except address
// - Address detection leaves sleep bit set
// - Transmit pin carries data only when enabled, or while draining a character queued while enabled
// - Disabling transmitter drains written characters first
// - Receive disabled: no buffer load, no receive interrupts
// - Shifter keeps assembling; enable checked at end
// - High and low bytes form 16-bit divisor
// - Bit rate is clock over 8*(divisor+1)
// - Divisor zero gives clock over 16
`default_nettype none
package uart_pkg;
   // Register word indices, byte address is four times the index
   localparam logic [15:0] IDX_CONTROL = 16'h7051;
   localparam logic [15:0] IDX_BAUD_HIGH = 16'h7052;
   localparam logic [15:0] IDX_BAUD_LOW = 16'h7053;
   localparam logic [15:0] IDX_TX_DATA = 16'h7054;
   localparam logic [15:0] IDX_RX_DATA = 16'h7055;
   localparam logic [15:0] IDX_RX_STATUS = 16'h7056;
   localparam logic [15:0] IDX_TX_STATUS = 16'h7057;
   localparam logic [15:0] IDX_INT_STATUS = 16'h7058;
   localparam logic [15:0] IDX_INT_MASK = 16'h7059;
   // Control bit positions
   localparam int CTL_RX_ENA = 0;
   localparam int CTL_TX_ENA = 1;
   localparam int CTL_SLEEP = 2;
   localparam int CTL_ADDR_MODE = 3;
   localparam int CTL_TX_WAKE = 4;
   // Receive status bit positions
   localparam int RXS_ERROR = 7;
   localparam int RXS_READY = 6;
   localparam int RXS_BREAK = 5;
   localparam int RXS_FRAME = 4;
   localparam int RXS_OVERRUN = 3;
   localparam int RXS_PARITY = 2;
   localparam int RXS_ADDR = 1;
   // Transmit status bit positions
   localparam int TXS_READY = 7;
   localparam int TXS_EMPTY = 6;
   // Interrupt status and mask bit positions
   localparam int INT_RX_READY = 0;
   localparam int INT_TX_READY = 1;
   localparam int INT_RX_ERROR = 2;
   localparam int INT_ADDR = 3;
   // Reset values and counts
   localparam logic [7:0] BAUD_RESET = 8'h00;
   localparam logic [15:0] ZERO_DIV_LIMIT = 16'h0001;
   localparam logic [2:0] PHASE_LAST = 3'h7;
   localparam logic [2:0] PHASE_MID = 3'h3;
   localparam logic [3:0] TX_BITS_PLAIN = 4'hA;
   localparam logic [3:0] TX_BITS_ADDR = 4'hB;
   localparam logic [3:0] RX_LAST_PLAIN = 4'h7;
   localparam logic [3:0] RX_LAST_ADDR = 4'h8;

   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

   typedef struct packed {
      logic [31:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic receiver_enable, transmitter_enable, sleep, addrMode, transmit_wake_select;
      logic [7:0] baudHi, baudLo;
      logic [15:0] tickCnt, tickLim;
      logic [7:0] txBuf;
      logic txFull, txArmed, txBusy;
      logic [10:0] txShift;
      logic [3:0] txLeft;
      logic [2:0] txPh;
      rx_state_t rxState;
      logic [2:0] rxPh;
      logic [3:0] rxBit;
      logic [8:0] rxShift;
      logic [7:0] rxBuf;
      logic rxReady, brk, fe, oe, addrSeen;
      logic [3:0] intStat, intMask;
      logic [31:0] prdata;
      logic pslverr;
   } state_t;
endpackage
`default_nettype wire

// [verilog/uart_enable_sleep_baud_gen.sv]
// The implementer's own choice: register access over APB.
`timescale 1ns/1ns
`default_nettype none
module uart_enable_sleep_baud_gen (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // APB slave
   input wire uart_pkg::apb_req_t apbReq,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial line
   input wire logic serialReceive,
   output logic serialTransmit,
   // Interrupt
   output logic irq
);
   import uart_pkg::*;

   state_t s;
   state_t next_s;

   // Word index match on a byte address
   function automatic logic hit(input logic [31:0] a, input logic [15:0] idx);
      hit = (a[17:2] == idx) && (a[31:18] == 14'h0000) && (a[1:0] == 2'b00);
   endfunction

   // Tick limit from divisor, zero divisor halves to clock over 16
   function automatic logic [15:0] limitOf(input logic [7:0] hi, input logic [7:0] lo);
      limitOf = ({hi, lo} == 16'h0000) ? ZERO_DIV_LIMIT : {hi, lo};
   endfunction

   logic setupPhase;
   logic accessPhase;
   logic tick;
   logic mapped;
   logic [7:0] rxData;
   logic rxAddrBit;
   logic isAddr;
   logic frameErr;
   logic rxUpdate;
   logic txStart;
   logic [3:0] events;

   assign setupPhase = apbReq.psel && !apbReq.penable;
   assign accessPhase = apbReq.psel && apbReq.penable;
   assign tick = (s.tickCnt == s.tickLim);
   assign mapped = hit(apbReq.paddr, IDX_CONTROL) || hit(apbReq.paddr, IDX_BAUD_HIGH)
      || hit(apbReq.paddr, IDX_BAUD_LOW) || hit(apbReq.paddr, IDX_TX_DATA)
      || hit(apbReq.paddr, IDX_RX_DATA) || hit(apbReq.paddr, IDX_RX_STATUS)
      || hit(apbReq.paddr, IDX_TX_STATUS) || hit(apbReq.paddr, IDX_INT_STATUS)
      || hit(apbReq.paddr, IDX_INT_MASK);

   // Received character fields, address bit sits above data in address mode
   assign rxData = s.addrMode ? s.rxShift[7:0] : s.rxShift[8:1];
   assign rxAddrBit = s.addrMode && s.rxShift[8];
   assign isAddr = rxAddrBit;
   assign frameErr = !serialReceive;
   assign rxUpdate = s.receiver_enable && (!s.sleep || isAddr);
   assign txStart = tick && !s.txBusy && s.txFull && (s.transmitter_enable || s.txArmed);

   // Outputs
   assign prdata = s.prdata;
   assign pready = 1'b1;
   assign pslverr = s.pslverr;
   assign serialTransmit = s.txShift[0];
   assign irq = |(s.intStat & s.intMask);

   // Next state
   always_comb begin
      next_s = s;
      events = 4'h0;

      // Baud tick generator, eight ticks per bit
      if (tick) begin
         next_s.tickCnt = 16'h0000;
         next_s.tickLim = limitOf(s.baudHi, s.baudLo);
      end else begin
         next_s.tickCnt = s.tickCnt + 16'h0001;
      end

      // Transmitter
      if (txStart) begin
         next_s.txShift = s.addrMode ? {1'b1, s.transmit_wake_select, s.txBuf, 1'b0} : {2'b11, s.txBuf, 1'b0};
         next_s.txLeft = s.addrMode ? TX_BITS_ADDR : TX_BITS_PLAIN;
         next_s.txBusy = 1'b1;
         next_s.txFull = 1'b0;
         next_s.txArmed = 1'b0;
         next_s.transmit_wake_select = 1'b0;
         next_s.txPh = 3'h0;
         events[INT_TX_READY] = 1'b1;
      end else if (tick && s.txBusy) begin
         next_s.txPh = s.txPh + 3'h1;
         if (s.txPh == PHASE_LAST) begin
            next_s.txShift = {1'b1, s.txShift[10:1]};
            next_s.txLeft = s.txLeft - 4'h1;
            if (s.txLeft == 4'h1) begin
               next_s.txBusy = 1'b0;
            end
         end
      end

      // Receiver shift logic runs whatever the enable
      if (tick) begin
         case (s.rxState)
            RX_IDLE: begin
               if (!serialReceive) begin
                  next_s.rxState = RX_START;
                  next_s.rxPh = 3'h0;
               end
            end
            RX_START: begin
               next_s.rxPh = s.rxPh + 3'h1;
               if (s.rxPh == PHASE_MID) begin
                  next_s.rxPh = 3'h0;
                  next_s.rxBit = 4'h0;
                  next_s.rxState = serialReceive ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA: begin
               next_s.rxPh = s.rxPh + 3'h1;
               if (s.rxPh == PHASE_LAST) begin
                  next_s.rxShift = {serialReceive, s.rxShift[8:1]};
                  next_s.rxBit = s.rxBit + 4'h1;
                  if (s.rxBit == (s.addrMode ? RX_LAST_ADDR : RX_LAST_PLAIN)) begin
                     next_s.rxState = RX_STOP;
                  end
               end
            end
            RX_STOP: begin
               next_s.rxPh = s.rxPh + 3'h1;
               if (s.rxPh == PHASE_LAST) begin
                  next_s.rxState = RX_IDLE;
                  if (rxUpdate) begin
                     next_s.rxBuf = rxData;
                     next_s.oe = s.rxReady;
                     next_s.fe = frameErr;
                     next_s.brk = frameErr && (rxData == 8'h00) && !isAddr;
                     next_s.addrSeen = isAddr;
                     events[INT_RX_READY] = 1'b1;
                     events[INT_RX_ERROR] = frameErr || s.rxReady;
                     events[INT_ADDR] = isAddr;
                  end
               end
            end
            default: begin
               next_s.rxState = RX_IDLE;
            end
         endcase
      end

      // Read data latched in the setup cycle
      if (setupPhase) begin
         next_s.prdata = 32'h0000_0000;
         next_s.pslverr = !mapped;
         if (hit(apbReq.paddr, IDX_CONTROL)) begin
            next_s.prdata[CTL_RX_ENA] = s.receiver_enable;
            next_s.prdata[CTL_TX_ENA] = s.transmitter_enable;
            next_s.prdata[CTL_SLEEP] = s.sleep;
            next_s.prdata[CTL_ADDR_MODE] = s.addrMode;
            next_s.prdata[CTL_TX_WAKE] = s.transmit_wake_select;
         end
         if (hit(apbReq.paddr, IDX_BAUD_HIGH)) begin
            next_s.prdata[7:0] = s.baudHi;
         end
         if (hit(apbReq.paddr, IDX_BAUD_LOW)) begin
            next_s.prdata[7:0] = s.baudLo;
         end
         if (hit(apbReq.paddr, IDX_RX_DATA)) begin
            next_s.prdata[7:0] = s.rxBuf;
         end
         if (hit(apbReq.paddr, IDX_RX_STATUS)) begin
            next_s.prdata[RXS_ERROR] = s.brk || s.fe || s.oe;
            next_s.prdata[RXS_READY] = s.rxReady;
            next_s.prdata[RXS_BREAK] = s.brk;
            next_s.prdata[RXS_FRAME] = s.fe;
            next_s.prdata[RXS_OVERRUN] = s.oe;
            next_s.prdata[RXS_PARITY] = 1'b0;
            next_s.prdata[RXS_ADDR] = s.addrSeen;
         end
         if (hit(apbReq.paddr, IDX_TX_STATUS)) begin
            next_s.prdata[TXS_READY] = !s.txFull;
            next_s.prdata[TXS_EMPTY] = !s.txFull && !s.txBusy;
         end
         if (hit(apbReq.paddr, IDX_INT_STATUS)) begin
            next_s.prdata[3:0] = s.intStat;
         end
         if (hit(apbReq.paddr, IDX_INT_MASK)) begin
            next_s.prdata[3:0] = s.intMask;
         end
      end

      // Register writes and read side effects at the access edge
      if (accessPhase && apbReq.pwrite) begin
         if (hit(apbReq.paddr, IDX_CONTROL)) begin
            next_s.receiver_enable = apbReq.pwdata[CTL_RX_ENA];
            next_s.transmitter_enable = apbReq.pwdata[CTL_TX_ENA];
            next_s.sleep = apbReq.pwdata[CTL_SLEEP];
            next_s.addrMode = apbReq.pwdata[CTL_ADDR_MODE];
            next_s.transmit_wake_select = apbReq.pwdata[CTL_TX_WAKE];
            if (s.transmitter_enable && s.txFull) begin
               next_s.txArmed = 1'b1;
            end
         end
         if (hit(apbReq.paddr, IDX_BAUD_HIGH)) begin
            next_s.baudHi = apbReq.pwdata[7:0];
         end
         if (hit(apbReq.paddr, IDX_BAUD_LOW)) begin
            next_s.baudLo = apbReq.pwdata[7:0];
         end
         if (hit(apbReq.paddr, IDX_TX_DATA)) begin
            next_s.txBuf = apbReq.pwdata[7:0];
            next_s.txFull = 1'b1;
            next_s.txArmed = s.transmitter_enable;
         end
         if (hit(apbReq.paddr, IDX_INT_STATUS)) begin
            next_s.intStat = s.intStat & ~apbReq.pwdata[3:0];
         end
         if (hit(apbReq.paddr, IDX_INT_MASK)) begin
            next_s.intMask = apbReq.pwdata[3:0];
         end
      end
      if (accessPhase && !apbReq.pwrite && hit(apbReq.paddr, IDX_RX_DATA)) begin
         next_s.rxReady = 1'b0;
      end

      // Hardware sets win over software clears
      if (events[INT_RX_READY]) begin
         next_s.rxReady = 1'b1;
      end
      next_s.intStat = next_s.intStat | events;
   end

   // State register
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         s <= '0;
         s.baudHi <= BAUD_RESET;
         s.baudLo <= BAUD_RESET;
         s.tickLim <= ZERO_DIV_LIMIT;
         s.txShift <= 11'h7FF;
         s.rxState <= RX_IDLE;
      end else begin
         s <= next_s;
      end
   end
endmodule // uart_enable_sleep_baud_gen
`default_nettype wire

// [tb/uart_enable_sleep_baud_gen_sva.sv]
`timescale 1ns/1ns
`default_nettype none
module uart_enable_sleep_baud_gen_chk (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // APB
   input wire uart_pkg::apb_req_t apbReq,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Serial line and interrupt
   input wire logic serialReceive,
   input wire logic serialTransmit,
   input wire logic irq
);
   import uart_pkg::*;
   logic [7:0] hi, lo;
   logic [3:0] ctl, mask;
   logic txOn, acc, bad, rdOk, wrOk;
   logic [15:0] idx;
   int bl, lowRun;
   // Access-phase decode and expected bit length
   assign acc = apbReq.psel && apbReq.penable;
   assign idx = apbReq.paddr[17:2];
   assign bad = apbReq.paddr[31:18] != 14'h0000 || apbReq.paddr[1:0] != 2'b00 || idx < IDX_CONTROL
      || idx > IDX_INT_MASK;
   assign wrOk = acc && !bad && apbReq.pwrite;
   assign rdOk = acc && !bad && !apbReq.pwrite;
   assign bl = ({hi, lo} == 16'h0000) ? 16 : 8 * (int'({hi, lo}) + 1);
   // Register shadows and low-run length of the transmit line
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         hi <= 8'h00;
         lo <= 8'h00;
         ctl <= 4'h0;
         mask <= 4'h0;
         txOn <= 1'b0;
         lowRun <= 0;
      end else begin
         if (wrOk && idx == IDX_BAUD_HIGH) hi <= apbReq.pwdata[7:0];
         if (wrOk && idx == IDX_BAUD_LOW) lo <= apbReq.pwdata[7:0];
         if (wrOk && idx == IDX_INT_MASK) mask <= apbReq.pwdata[3:0];
         if (wrOk && idx == IDX_CONTROL) ctl <= apbReq.pwdata[3:0];
         if (wrOk && idx == IDX_CONTROL && apbReq.pwdata[CTL_TX_ENA]) txOn <= 1'b1;
         lowRun <= serialTransmit ? 0 : lowRun + 1;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   a_ready_high: assert property (pready) else $error("pready low");
   a_unmapped_err: assert property (acc && bad |-> pslverr && prdata == 32'h0000_0000) else $error("no error");
   a_mapped_ok: assert property (acc && !bad |-> !pslverr) else $error("spurious error");
   a_baud_high: assert property (rdOk && idx == IDX_BAUD_HIGH |-> prdata == {24'h00_0000, hi})
      else $error("high divisor byte wrong");
   a_baud_low: assert property (rdOk && idx == IDX_BAUD_LOW |-> prdata == {24'h00_0000, lo})
      else $error("low divisor byte wrong");
   a_ctrl_hold: assert property (rdOk && idx == IDX_CONTROL |-> prdata[3:0] == ctl)
      else $error("control bits changed");
   a_irq_mask: assert property (irq |-> mask != 4'h0) else $error("irq while masked");
   a_tx_quiet: assert property (!txOn |-> serialTransmit) else $error("transmit while never enabled");
   a_bit_len: assert property ($rose(serialTransmit) |-> (lowRun % bl) == 0)
      else $error("bit length wrong");
   c_tx_frame: cover property ($fell(serialTransmit));
   c_irq: cover property (irq);
   c_unmapped: cover property (acc && bad);
endmodule // uart_enable_sleep_baud_gen_chk
bind uart_enable_sleep_baud_gen uart_enable_sleep_baud_gen_chk chk (.core_clk, .reset_n, .apbReq, .prdata,
   .pready, .pslverr, .serialReceive, .serialTransmit, .irq);
`default_nettype wire

// [tb/serial_peer.sv]
`timescale 1ns/1ns
`default_nettype none
module serial_peer (
   // Clock
   input wire logic core_clk,
   // Line toward the receiver
   output logic line
);
   // Idle mark level between frames
   initial line = 1'b1;
   // One frame: start, data LSB first, optional address bit, stop
   task automatic send(input logic [7:0] d, input logic useAb, input logic ab, input int bitLen);
      logic [10:0] f;
      int n;
      f = useAb ? {1'b1, ab, d, 1'b0} : {2'b11, d, 1'b0};
      n = useAb ? 11 : 10;
      for (int i = 0; i < n; i++) begin
         @(posedge core_clk);
         line <= f[i];
         repeat (bitLen - 1) @(posedge core_clk);
      end
   endtask
endmodule // serial_peer
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb;
   import uart_pkg::*;
   logic core_clk, reset_n, pready, pslverr, serialReceive, serialTransmit, irq, err;
   apb_req_t apbReq;
   logic [31:0] prdata, rdat;
   int fail_count, n_tests;
   int cyc = 0;
   uart_enable_sleep_baud_gen dut (.core_clk, .reset_n, .apbReq, .prdata, .pready, .pslverr, .serialReceive,
      .serialTransmit, .irq);
   serial_peer peer (.core_clk, .line(serialReceive));
   // Clock
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic summarize;
      $display("Checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // APB transfer: setup, then access until pready
   task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
      @(posedge core_clk);
      apbReq.paddr <= {14'h0000, idx, 2'b00};
      apbReq.pwrite <= w;
      apbReq.pwdata <= d;
      apbReq.psel <= 1'b1;
      @(posedge core_clk);
      apbReq.penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rdat = prdata;
      err = pslverr;
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [15:0] idx, input string nm, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0000_0000);
      chk(nm, rdat, exp);
   endtask
   // Length of the next start bit on the transmit line
   task automatic txstart(input int exp);
      int n;
      n = 0;
      while (serialTransmit === 1'b1 && n < 3000) begin
         @(posedge core_clk);
         n++;
      end
      n = 0;
      while (serialTransmit === 1'b0) begin
         @(posedge core_clk);
         n++;
      end
      chk("startBit", n, exp);
   endtask
   // Hang guard
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fail_count++;
         summarize();
      end
   end
   initial begin
      reset_n = 1'b0;
      apbReq = '0;
      fail_count = 0;
      n_tests = 0;
      repeat (8) @(posedge core_clk);
      reset_n <= 1'b1;
      rd(IDX_BAUD_HIGH, "baudHi", 32'h0000_0000);
      rd(IDX_BAUD_LOW, "baudLo", 32'h0000_0000);
      rd(IDX_CONTROL, "ctl", 32'h0000_0000);
      rd(16'h7060, "unmapped", 32'h0000_0000);
      chk("pslverr", err, 32'h0000_0001);
      // Character held while the transmitter is off
      apb(1'b1, IDX_TX_DATA, 32'h0000_00FF);
      repeat (100) @(posedge core_clk);
      chk("txIdle", serialTransmit, 32'h0000_0001);
      rd(IDX_TX_STATUS, "txHeld", 32'h0000_0000);
      apb(1'b1, IDX_CONTROL, 32'h0000_0002);
      txstart(16);
      repeat (160) @(posedge core_clk);
      apb(1'b1, IDX_BAUD_HIGH, 32'h0000_0001);
      rd(IDX_BAUD_HIGH, "baudHi", 32'h0000_0001);
      apb(1'b1, IDX_TX_DATA, 32'h0000_00FF);
      txstart(2056);
      repeat (20600) @(posedge core_clk);
      rd(IDX_TX_STATUS, "txEmpty", 32'h0000_00C0);
      apb(1'b1, IDX_BAUD_HIGH, 32'h0000_0000);
      apb(1'b1, IDX_BAUD_LOW, 32'h0000_0002);
      rd(IDX_BAUD_LOW, "baudLo", 32'h0000_0002);
      // Disable right after a write: the character still goes out
      fork
         txstart(24);
         begin
            apb(1'b1, IDX_TX_DATA, 32'h0000_00FF);
            apb(1'b1, IDX_CONTROL, 32'h0000_0000);
         end
      join
      repeat (300) @(posedge core_clk);
      rd(IDX_TX_STATUS, "txDrained", 32'h0000_00C0);
      apb(1'b1, IDX_TX_DATA, 32'h0000_000F);
      repeat (300) @(posedge core_clk);
      chk("txOff", serialTransmit, 32'h0000_0001);
      rd(IDX_TX_STATUS, "txOffHeld", 32'h0000_0000);
      // Receiver off, then enabled mid-character
      peer.send(8'h3C, 1'b0, 1'b0, 24);
      rd(IDX_RX_STATUS, "rxOff", 32'h0000_0000);
      rd(IDX_INT_STATUS, "intOff", 32'h0000_0002);
      fork
         peer.send(8'hA5, 1'b0, 1'b0, 24);
         begin
            repeat (120) @(posedge core_clk);
            apb(1'b1, IDX_CONTROL, 32'h0000_0001);
         end
      join
      rd(IDX_RX_STATUS, "rxMid", 32'h0000_0040);
      // Interrupt raised, masked and cleared
      apb(1'b1, IDX_INT_MASK, 32'h0000_0001);
      chk("irqOn", irq, 32'h0000_0001);
      apb(1'b1, IDX_INT_MASK, 32'h0000_0000);
      chk("irqMask", irq, 32'h0000_0000);
      apb(1'b1, IDX_INT_MASK, 32'h0000_0001);
      apb(1'b1, IDX_INT_STATUS, 32'h0000_0001);
      chk("irqClr", irq, 32'h0000_0000);
      rd(IDX_RX_DATA, "rxData", 32'h0000_00A5);
      // Sleep in address-bit mode
      apb(1'b1, IDX_CONTROL, 32'h0000_000D);
      peer.send(8'h11, 1'b1, 1'b0, 24);
      rd(IDX_RX_STATUS, "sleepData", 32'h0000_0000);
      peer.send(8'h22, 1'b1, 1'b1, 24);
      rd(IDX_RX_STATUS, "sleepAddr", 32'h0000_0042);
      rd(IDX_CONTROL, "sleepHeld", 32'h0000_000D);
      rd(IDX_RX_DATA, "addrData", 32'h0000_0022);
      apb(1'b1, IDX_CONTROL, 32'h0000_0009);
      peer.send(8'h33, 1'b1, 1'b0, 24);
      rd(IDX_RX_DATA, "wakeData", 32'h0000_0033);
      summarize();
   end
endmodule // tb
`default_nettype wire
